/* sta_pkg.sv */
// Shared constants for the sensor telegram assembler.
package sta_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned WAKE_MIN_S      = 1;
  localparam int unsigned WAKE_MAX_S      = 65534;
  localparam logic [7:0]  THR0_RST        = 8'h06;
  localparam logic [7:0]  THR1_RST        = 8'h05;
  localparam logic [7:0]  THR2_RST        = 8'h0e;
  localparam logic [3:0]  DMASK_RST       = 4'h0;
  localparam int unsigned DELAY_STEP_MS   = 2;
  localparam int unsigned DELAY_MAX_MS    = 508;
  localparam logic [7:0]  DELAY_RST       = 8'h01;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_STEP    = DELAY_STEP_MS * CYC_PER_MS;
  localparam logic [7:0]  TYPE_CODE       = 8'h07;
  localparam logic [1:0]  EDGE_RISE       = 2'h1;
  localparam logic [1:0]  EDGE_FALL       = 2'h2;
  localparam logic [1:0]  EDGE_BOTH       = 2'h3;
  localparam int unsigned RPT_FIX         = 2;
  localparam int unsigned DB2_CH1_LSB     = 2;
  localparam int unsigned TELEGRAM_BYTES  = 9;
endpackage

/* sta_top.sv */
// Sensor telegram assembler: wake handling, sampling, change test, packing.
`timescale 1ns/10ps
`default_nettype none
module sta_top #(
  parameter int unsigned CYC_PER_S = 100_000_000,
  parameter logic [31:0] MODULE_ID = 32'h0000_0001 // Arbitrary value.
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        wake_pin0_in,
  input  wire logic        wake_pin1_in,
  input  wire logic [3:0]  digital_input_in,
  input  wire logic        adc_done_in,
  input  wire logic [9:0]  adc_code_in,
  input  wire logic [15:0] cfg_wake_period_in,
  input  wire logic [7:0]  cfg_rpt_min_in,
  input  wire logic [7:0]  cfg_rpt_max_in,
  input  wire logic        cfg_thr_load_in,
  input  wire logic [9:0]  cfg_thr0_in,
  input  wire logic [9:0]  cfg_thr1_in,
  input  wire logic [9:0]  cfg_thr2_in,
  input  wire logic        cfg_mixed_res_in,
  input  wire logic [3:0]  cfg_dmask_in,
  input  wire logic [7:0]  cfg_delay_in,
  input  wire logic        cfg_ch2_supply_in,
  input  wire logic        cfg_supply_invert_in,
  input  wire logic [1:0]  cfg_edge0_in,
  input  wire logic [1:0]  cfg_edge1_in,
  input  wire logic        tx_ready_in,
  output logic             sensor_supply_control_out,
  output logic             adc_start_out,
  output logic [1:0]       adc_chan_out,
  output logic             adc_supply_sel_out,
  output logic [7:0]       tx_byte_out,
  output logic             tx_valid_out,
  output logic             tx_last_out
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_CONV, ST_WAIT,
                            ST_DECIDE, ST_SEND} sta_state_e;
  sta_state_e  st_q;
  logic [1:0]  w0_s_q, w1_s_q, w0_q, w1_q;
  logic [3:0]  di_s1_q, di_s2_q, di_last_q;
  logic [31:0] sec_cnt_q;
  logic [15:0] sec_q;
  logic [9:0]  thr_q [3];
  logic [9:0]  smp_q [3];
  logic [9:0]  last_q [3];
  logic [7:0]  rpt_q, lfsr_q;
  logic [31:0] dly_q;
  logic [1:0]  ch_q;
  logic [3:0]  idx_q;
  logic        force_q, timer_wake;
  logic        supply_on_q;

  // Two-stage synchronisers; pin levels enter logic only after stage two.
  // The third and fourth stages give the current and previous level for edges.
  always_ff @(posedge clk_in) begin
    w0_s_q <= {w0_s_q[0], wake_pin0_in};
    w1_s_q <= {w1_s_q[0], wake_pin1_in};
    w0_q   <= {w0_q[0], w0_s_q[1]};
    w1_q   <= {w1_q[0], w1_s_q[1]};
    di_s1_q <= digital_input_in;
    di_s2_q <= di_s1_q;
  end

  // Edge classification per pin; any edge wakes, chosen edges force a send.
  logic rise0, fall0, rise1, fall1, pin_wake, pin_send;
  assign rise0 = w0_q[0] & ~w0_q[1];
  assign fall0 = ~w0_q[0] & w0_q[1];
  assign rise1 = w1_q[0] & ~w1_q[1];
  assign fall1 = ~w1_q[0] & w1_q[1];
  assign pin_wake = rise0 | fall0 | rise1 | fall1;
  assign pin_send = (rise0 & cfg_edge0_in[0]) | (fall0 & cfg_edge0_in[1])
                  | (rise1 & cfg_edge1_in[0])
                  | (fall1 & cfg_edge1_in[1]);

  ////////////////////////////////////////////////////////////////////////
  // Wake timer in whole seconds; period 0 or above the top is clamped.
  logic [15:0] period;
  always_comb begin
    period = cfg_wake_period_in;
    if (period < 16'(sta_pkg::WAKE_MIN_S)) period = 16'(sta_pkg::WAKE_MIN_S);
    if (period > 16'(sta_pkg::WAKE_MAX_S)) period = 16'(sta_pkg::WAKE_MAX_S);
  end
  // The wake fires on the last cycle of the final second, so the period is
  // exact in whole seconds and the seconds counter restarts from zero.
  assign timer_wake = (sec_cnt_q == CYC_PER_S - 1)
                   && (sec_q + 16'h1 >= period);
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sec_cnt_q <= 32'h0;
      sec_q     <= 16'h0;
    end else if (sec_cnt_q == CYC_PER_S - 1) begin
      sec_cnt_q <= 32'h0;
      sec_q     <= timer_wake ? 16'h0 : sec_q + 16'h1;
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Thresholds load at reset, or when the stored area is rewritten; the load
  // is taken in any state, even in the middle of a wake cycle.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      thr_q[0] <= {2'h0, sta_pkg::THR0_RST};
      thr_q[1] <= {2'h0, sta_pkg::THR1_RST};
      thr_q[2] <= {2'h0, sta_pkg::THR2_RST};
    end else if (cfg_thr_load_in) begin
      thr_q[0] <= cfg_thr0_in;
      thr_q[1] <= cfg_thr1_in;
      thr_q[2] <= cfg_thr2_in;
    end
  end

  // Random source for the retransmit reload.
  // The modulo reduction is slightly uneven across the span; accepted here.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) lfsr_q <= 8'h5a;
    else lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  logic [7:0] span, rnd;
  assign span = cfg_rpt_max_in - cfg_rpt_min_in;
  assign rnd  = (cfg_rpt_max_in <= cfg_rpt_min_in) ? cfg_rpt_min_in
              : cfg_rpt_min_in + 8'(lfsr_q % ({1'b0, span} + 9'h1));

  ////////////////////////////////////////////////////////////////////////
  // Change detection against last transmitted values.
  // The threshold is clamped to the channel's full scale, so a stored value
  // above it means that channel can never trigger a telegram on its own.
  logic [9:0] fs [3];
  logic       ana_chg, dig_chg;
  always_comb begin
    fs[0] = cfg_mixed_res_in ? 10'h3ff : 10'h0ff;
    fs[1] = cfg_mixed_res_in ? 10'h03f : 10'h0ff;
    fs[2] = 10'h0ff;
    ana_chg = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (((smp_q[i] > last_q[i]) ? smp_q[i] - last_q[i]
           : last_q[i] - smp_q[i]) > ((thr_q[i] > fs[i]) ? fs[i] : thr_q[i]))
        ana_chg = 1'b1;
    end
  end
  assign dig_chg = |((di_s2_q ^ di_last_q) & ~cfg_dmask_in);

  ////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer so a stalled radio loses no byte. The head
  // entry drives the pins from its own flip-flops; the spare entry only
  // catches the byte pushed in a cycle when the head is stalled.
  logic [8:0] spare_q;
  logic       spare_vld_q;
  logic       push, pop, in_ready;
  logic [7:0] pay [sta_pkg::TELEGRAM_BYTES];
  logic [8:0] push_word;
  // Accepting only into an empty spare costs a bubble after a stall but
  // keeps the ready path free of the consumer's ready input.
  assign in_ready = !spare_vld_q;
  assign push = (st_q == ST_SEND) && in_ready;
  assign pop  = tx_valid_out && tx_ready_in;
  // Payload bytes in send order; the digital byte is the value captured
  // at the decision, so a late input change cannot tear the telegram.
  always_comb begin
    pay[0] = sta_pkg::TYPE_CODE;
    pay[1] = smp_q[2][7:0];
    pay[2] = cfg_mixed_res_in ? {smp_q[1][5:0], smp_q[0][9:8]}
           : smp_q[1][7:0];
    pay[3] = smp_q[0][7:0];
    pay[4] = {4'h0, di_last_q};
    pay[5] = MODULE_ID[31:24];
    pay[6] = MODULE_ID[23:16];
    pay[7] = MODULE_ID[15:8];
    pay[8] = MODULE_ID[7:0];
  end
  assign push_word = {idx_q == 4'(sta_pkg::TELEGRAM_BYTES - 1), pay[idx_q]};
  // Head reloads when empty or taken; a stalled head holds still.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_valid_out <= 1'b0;
      tx_byte_out  <= 8'h0;
      tx_last_out  <= 1'b0;
      spare_q      <= 9'h0;
      spare_vld_q  <= 1'b0;
    end else if (pop || !tx_valid_out) begin
      if (spare_vld_q) begin
        {tx_last_out, tx_byte_out} <= spare_q;
        tx_valid_out <= 1'b1;
        spare_vld_q  <= 1'b0;
      end else begin
        {tx_last_out, tx_byte_out} <= push_word;
        tx_valid_out <= push;
      end
    end else if (push) begin
      spare_q     <= push_word;
      spare_vld_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: wake, power sensors, wait, convert three channels, decide.
  // Wakes arriving mid-cycle are dropped; only a pin send request is kept.
  // The delay counts clock cycles, so zero steps samples right away.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_q <= ST_IDLE;
      force_q <= 1'b0;
      rpt_q <= 8'(sta_pkg::RPT_FIX);
      dly_q <= 32'h0;
      ch_q <= 2'h0;
      idx_q <= 4'h0;
      adc_start_out <= 1'b0;
      supply_on_q <= 1'b0;
      di_last_q <= 4'h0;
      for (int i = 0; i < 3; i++) begin
        smp_q[i] <= 10'h0;
        last_q[i] <= 10'h0;
      end
    end else begin
      adc_start_out <= 1'b0;
      case (st_q)
        ST_IDLE: if (pin_wake || timer_wake) begin
          if (timer_wake && !pin_wake) begin
            if (rpt_q <= 8'h1) force_q <= 1'b1;
            else rpt_q <= rpt_q - 8'h1;
          end
          supply_on_q <= 1'b1;
          dly_q <= 32'(cfg_delay_in) * sta_pkg::CYC_PER_STEP;
          st_q <= ST_DELAY;
        end
        ST_DELAY: if (dly_q == 32'h0) begin
          ch_q <= 2'h0;
          st_q <= ST_CONV;
        end else dly_q <= dly_q - 32'h1;
        ST_CONV: begin
          adc_start_out <= 1'b1;
          st_q <= ST_WAIT;
        end
        ST_WAIT: if (adc_done_in) begin
          smp_q[ch_q] <= adc_code_in & fs[ch_q];
          if (ch_q == 2'h2) begin
            supply_on_q <= 1'b0;
            st_q <= ST_DECIDE;
          end else begin
            ch_q <= ch_q + 2'h1;
            st_q <= ST_CONV;
          end
        end
        ST_DECIDE: begin
          idx_q <= 4'h0;
          if (ana_chg || dig_chg || force_q || pin_send) begin
            force_q <= 1'b0;
            rpt_q <= rnd;
            di_last_q <= di_s2_q;
            for (int i = 0; i < 3; i++) last_q[i] <= smp_q[i];
            st_q <= ST_SEND;
          end else st_q <= ST_IDLE;
        end
        ST_SEND: if (push) begin
          if (idx_q == 4'(sta_pkg::TELEGRAM_BYTES - 1)) st_q <= ST_IDLE;
          idx_q <= idx_q + 4'h1;
        end
        default: st_q <= ST_IDLE;
      endcase
      // After the case, so a new pin request beats the clear at the decision.
      if (pin_send) force_q <= 1'b1;
    end
  end

  // Supply control and channel-two source, registered at the pins.
  // The inverted level also holds while idle, except that reset drives 0; the first edge after reset loads the inverted level.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sensor_supply_control_out <= 1'b0;
      adc_chan_out <= 2'h0;
      adc_supply_sel_out <= 1'b0;
    end else begin
      sensor_supply_control_out <= supply_on_q ^ cfg_supply_invert_in;
      adc_chan_out <= ch_q;
      adc_supply_sel_out <= (ch_q == 2'h2) && cfg_ch2_supply_in;
    end
  end
endmodule
`default_nettype wire

/* sta_top_asserts.sv */
// Concurrent checks on the telegram assembler ports.
`timescale 1ns/10ps
`default_nettype none
module sta_top_asserts #(
  parameter logic [31:0] MODULE_ID = 32'h0000_0001
) (
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic       tx_ready_in,
  input wire logic       cfg_supply_invert_in,
  input wire logic       cfg_ch2_supply_in,
  input wire logic       sensor_supply_control_out,
  input wire logic       adc_start_out,
  input wire logic [1:0] adc_chan_out,
  input wire logic       adc_supply_sel_out,
  input wire logic [7:0] tx_byte_out,
  input wire logic       tx_valid_out,
  input wire logic       tx_last_out
);
  logic [3:0] idx_q;
  // Byte position in the telegram, so each check knows which byte it sees.
  always_ff @(posedge clk_in) begin
    if (!nrst_in || (tx_valid_out && tx_ready_in && tx_last_out)) begin
      idx_q <= 4'h0;
    end else if (tx_valid_out && tx_ready_in) begin
      idx_q <= idx_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_stall; tx_valid_out && !tx_ready_in; endsequence
  sequence s_held;
    tx_valid_out && $stable(tx_byte_out) && $stable(tx_last_out);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_type_code: assert property (
    tx_valid_out && idx_q == 4'h0 |-> tx_byte_out == sta_pkg::TYPE_CODE)
    else $error("type code byte wrong");
  a_reserved_zero: assert property (
    tx_valid_out && idx_q == 4'h4 |-> tx_byte_out[7:4] == 4'h0)
    else $error("reserved input bits not zero");
  a_id_order: assert property (
    tx_valid_out && idx_q >= 4'h5 && idx_q <= 4'h8
    |-> tx_byte_out == MODULE_ID[8*(8-idx_q) +: 8])
    else $error("identifier byte wrong");
  a_last_flag: assert property (
    tx_valid_out |-> tx_last_out == (idx_q == 4'h8))
    else $error("last flag misplaced");
  // A stalled byte must not move, or the receiver would lose it.
  a_stall_hold: assert property (s_stall |=> s_held)
    else $error("stalled byte changed");
  a_start_pulse: assert property (adc_start_out |=> !adc_start_out)
    else $error("conversion start longer than one cycle");
  a_supply_on: assert property (
    adc_start_out |-> sensor_supply_control_out ^ cfg_supply_invert_in)
    else $error("sensors unpowered at sampling");
  a_ch2_source: assert property (
    adc_start_out && adc_chan_out == 2'h2
    |-> adc_supply_sel_out == cfg_ch2_supply_in)
    else $error("channel two source wrong");
  a_reset_quiet: assert property (disable iff (1'b0)
    !nrst_in |=> !tx_valid_out && !adc_start_out)
    else $error("output active after reset");
endmodule
`default_nettype wire

/* sta_adc_model.sv */
// Converter model answering conversion starts with a per-channel code.
`timescale 1ns/10ps
`default_nettype none
module sta_adc_model (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        slow_in,
  input  wire logic        adc_start_in,
  input  wire logic [1:0]  adc_chan_in,
  input  wire logic [29:0] codes_in,
  output logic             adc_done_out,
  output logic [9:0]       adc_code_out
);
  logic [4:0] wait_q;
  logic [1:0] chan_q;
  // Code inverts every cycle outside the done pulse, so a read one cycle late looks wrong.
  always_ff @(posedge clk_in) begin
    adc_done_out <= 1'b0;
    adc_code_out <= ~adc_code_out;
    if (!nrst_in) begin
      wait_q <= 5'h0;
      adc_code_out <= 10'h0;
    end else if (adc_start_in) begin
      wait_q <= slow_in ? 5'h14 : 5'h2;
      chan_q <= adc_chan_in;
    end else if (wait_q == 5'h1) begin
      wait_q <= 5'h0;
      adc_done_out <= 1'b1;
      adc_code_out <= codes_in[10*chan_q +: 10];
    end else if (wait_q != 5'h0) begin
      wait_q <= wait_q - 5'h1;
    end
  end
endmodule
`default_nettype wire

/* sensor_telegram_assembler_tb.sv */
// Self-checking bench for the telegram assembler.
`timescale 1ns/10ps
`default_nettype none
module sensor_telegram_assembler_tb;
  localparam logic [31:0] MOD_ID = 32'h1234_5678; // Arbitrary value.
  typedef struct packed {
    logic mix; logic [29:0] code; logic [3:0] din; logic [31:0] exp;
  } sta_row_s;
  sta_row_s rows [4] = '{
    '{1'b0, {10'h056, 10'h034, 10'h012}, 4'ha, 32'h5634_120a},
    '{1'b1, {10'h0c3, 10'h02c, 10'h3a5}, 4'h5, 32'hc3b3_a505},
    '{1'b0, {10'h080, 10'h000, 10'h0ff}, 4'hf, 32'h8000_ff0f},
    '{1'b1, {10'h001, 10'h03f, 10'h2ff}, 4'h0, 32'h01fe_ff00}};
  logic clk_in = 0, nrst_in = 0, w0 = 0, w1 = 0, rdy = 0, slow = 0;
  logic mix = 0, inv = 0, ch2s = 0, done, start, supply, ssel, vld, last;
  logic thr_load = 0;
  logic [3:0] din = 0, dmask = 0;
  logic [1:0] e0 = sta_pkg::EDGE_BOTH, e1 = sta_pkg::EDGE_BOTH, chan;
  logic [9:0] code, thr0 = 10'h006;
  logic [7:0] rmax = 8'h02;
  logic [29:0] codes = 0;
  logic [7:0] byt;
  int failures = 0, checked = 0, cyc = 0;
  sta_top #(.CYC_PER_S(100), .MODULE_ID(MOD_ID)) i_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .wake_pin0_in(w0),
    .wake_pin1_in(w1), .digital_input_in(din), .adc_done_in(done),
    .adc_code_in(code), .cfg_wake_period_in(16'hfffe),
    .cfg_rpt_min_in(8'h02), .cfg_rpt_max_in(rmax), .cfg_thr_load_in(thr_load),
    .cfg_thr0_in(thr0), .cfg_thr1_in(10'h005), .cfg_thr2_in(10'h00e),
    .cfg_mixed_res_in(mix), .cfg_dmask_in(dmask), .cfg_delay_in(8'h00),
    .cfg_ch2_supply_in(ch2s), .cfg_supply_invert_in(inv), .cfg_edge0_in(e0),
    .cfg_edge1_in(e1), .tx_ready_in(rdy),
    .sensor_supply_control_out(supply), .adc_start_out(start),
    .adc_chan_out(chan), .adc_supply_sel_out(ssel), .tx_byte_out(byt),
    .tx_valid_out(vld), .tx_last_out(last));
  sta_adc_model i_adc (.clk_in(clk_in), .nrst_in(nrst_in), .slow_in(slow),
    .adc_start_in(start), .adc_chan_in(chan), .codes_in(codes),
    .adc_done_out(done), .adc_code_out(code));
  always #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////
  // Cycle ceiling well above the fewer than two thousand cycles the tests need.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("wrong value t=%0t got=%h exp=%h", $time, cyc, 0);
      print_verdict;
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Takes one telegram while stalling the consumer every fourth cycle.
  task recv(input logic [31:0] d);
    logic [71:0] e;
    int i, n;
    e = {sta_pkg::TYPE_CODE, d, MOD_ID};
    i = 0;
    n = 0;
    while (i < 9 && n < 2000) begin
      @(negedge clk_in);
      n++;
      rdy = n[1:0] != 2'h0;
      // A byte seen with ready now is the one taken at the next rising edge.
      if (vld === 1'b1 && rdy) begin
        chk(byt, e[71-8*i -: 8]);
        chk({7'h0, last}, {7'h0, i == 8});
        i++;
      end
    end
    @(negedge clk_in);
    rdy = 1'b0;
    if (i < 9) begin
      failures++;
      $display("wrong value t=%0t got=%h exp=%h", $time, i, 9);
    end
  endtask
  // Watches the telegram output stay idle for a number of cycles.
  task quiet(input int cycles);
    repeat (cycles) begin
      @(negedge clk_in);
      chk({7'h0, vld}, 8'h00);
    end
  endtask
  task print_verdict;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_in);
    chk({5'h0, supply, vld, start}, 8'h00);
    nrst_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {mix, codes, din} = {rows[i].mix, rows[i].code, rows[i].din};
      {slow, ch2s, inv} = {i[0], i[0], i[1]};
      repeat (6) @(negedge clk_in);
      if (i[0]) w1 = ~w1; else w0 = ~w0;
      recv(rows[i].exp);
    end
    // Rising edge with falling-only selected wakes but must stay silent.
    e0 = sta_pkg::EDGE_FALL;
    @(negedge clk_in);
    w0 = 1'b1;
    quiet(400);
    w0 = 1'b0;
    recv(rows[3].exp);
    // A masked input change must not send; unmasked it must.
    {dmask, din} = 8'h11;
    repeat (6) @(negedge clk_in);
    w0 = 1'b1;
    quiet(400);
    {dmask, e0} = {4'h0, sta_pkg::EDGE_RISE};
    @(negedge clk_in);
    w0 = 1'b0;
    recv(32'h01fe_ff01);
    // A move of three stays inside the reset threshold until it is zeroed.
    e0 = sta_pkg::EDGE_FALL;
    codes = {10'h001, 10'h03f, 10'h302};
    repeat (6) @(negedge clk_in);
    w0 = 1'b1;
    quiet(400);
    {thr_load, thr0, e0} = {1'b1, 10'h000, sta_pkg::EDGE_RISE};
    @(negedge clk_in);
    thr_load = 1'b0;
    w0 = 1'b0;
    recv(32'h01ff_0201);
    print_verdict;
  end
endmodule
bind sta_top sta_top_asserts #(.MODULE_ID(MODULE_ID)) i_chk (
  .clk_in(clk_in), .nrst_in(nrst_in), .tx_ready_in(tx_ready_in),
  .cfg_supply_invert_in(cfg_supply_invert_in),
  .cfg_ch2_supply_in(cfg_ch2_supply_in),
  .sensor_supply_control_out(sensor_supply_control_out),
  .adc_start_out(adc_start_out), .adc_chan_out(adc_chan_out),
  .adc_supply_sel_out(adc_supply_sel_out), .tx_byte_out(tx_byte_out),
  .tx_valid_out(tx_valid_out), .tx_last_out(tx_last_out));
`default_nettype wire
